// ---- placeholder_end.sv ----
// Intentionally empty: no further design content
`timescale 1ns/10ps

// ---- sad_bus_master.sv ----
// Bus master model that issues decoder accesses
`timescale 1ns/10ps
module sad_bus_master (
    input wire logic mclk_in,
    output logic req_valid_out,
    output logic [31:0] req_addr_out
);
    // Bus idle at start
    initial begin
        req_valid_out = 1'b0;
        req_addr_out = 32'h0;
    end
    // One access, launched off the falling edge
    task automatic access(input logic [31:0] a);
        @(negedge mclk_in);
        req_valid_out = 1'b1;
        req_addr_out = a;
    endtask
    // Release; stale address shown inverted
    task automatic release_bus();
        @(negedge mclk_in);
        req_valid_out = 1'b0;
        req_addr_out = ~req_addr_out;
    endtask
endmodule

// ---- sad_cfg.svh ----
// Address map, identifier and timing constants for the system address decoder
`ifndef SAD_CFG_SVH
`define SAD_CFG_SVH
// Area field: four top address bits split 4 GB into 16 x 256 MB
`define SAD_AREA_MSB 31
`define SAD_AREA_LSB 28
`define SAD_AREA_INT 4'h0
`define SAD_AREA_CS_FIRST 4'h1
`define SAD_AREA_CS_LAST 4'h8
`define SAD_AREA_PERIPH 4'hf
// Second level inside area 0: 1 MB slots
`define SAD_SLOT_MSB 27
`define SAD_SLOT_LSB 20
`define SAD_SLOT_BOOT 8'h00
`define SAD_SLOT_ROM 8'h01
`define SAD_SLOT_SRAM 8'h02
`define SAD_SLOT_USB_HOST 8'h03
// Offset passed to the target: everything below the area field
`define SAD_OFFSET_MSB 27
// Positions of the pins inside the synchroniser words
`define SAD_PIN_FAST 0
`define SAD_PIN_EXT_LSB 1
`define SAD_PIN_EXT_MSB 7
`define SAD_PIN_BOOT 8
// Interrupt / clock-gate identifiers
`define SAD_ID_FAST 0
`define SAD_ID_SYS 1
`define SAD_ID_PER_LO 2
`define SAD_ID_PER_HI 24
`define SAD_ID_EXT_LO 25
`define SAD_ID_EXT_HI 31
// Identifiers that own a peripheral clock gate (2..24)
`define SAD_GATE_MASK 32'h01ff_fffc
// Cycles after reset release during which the boot strap is tracked
`define SAD_STRAP_CYCLES 2'h3
`endif

// ---- sad_decoder.sv ----
// System address decoder with boot remap and interrupt identifier numbering
// Functional notes
// - Top four address bits pick 256MB area
// - Areas 1-8 drive chip selects 0-7
// - Area 0 goes to internal 1MB slots
// - Area 15 goes to peripheral bridge
// - Areas 9-14 answer with abort
// - SRAM always at 0x200000
// - After remap SRAM also at 0x0
// - ROM always at 0x100000
// - Before remap ROM at 0x0 if strap high
// - USB host registers at 0x300000
// - System interrupt ORs five system sources
// - Identifier 1 carries system interrupt, ungated
// - Fixed identifier numbering 0 to 31
// - Identifier indexes interrupt and clock gate
// - Fast and external lines have no gate
`timescale 1ns/10ps
`include "sad_cfg.svh"
module sad_decoder (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire logic [31:0] req_addr_in,
    input wire logic remap_cmd_in,
    input wire logic boot_memory_select_in,
    input wire logic fast_interrupt_line_in,
    input wire logic [6:0] external_interrupt_line_in,
    input wire sad_pkg::sad_sys_irq_t sys_irq_in,
    input wire logic [31:0] periph_irq_in,
    input wire logic [31:0] clk_en_req_in,
    output sad_pkg::sad_route_t route_out,
    output logic remap_active_out,
    output logic boot_rom_alias_out,
    output logic [31:0] irq_vec_out,
    output logic [31:0] clk_en_out
);
    import sad_pkg::*;

    sad_state_t st_r;
    sad_state_t st_nxt;

    // ************************************************************
    // Address decode
    // ************************************************************

    // Two-level decode of one address
    function automatic sad_route_t decode(input logic [31:0] addr,
                                          input logic remap,
                                          input logic boot_rom);
        sad_route_t r;
        logic [3:0] area;
        logic [7:0] slot;
        r = '0;
        area = addr[`SAD_AREA_MSB:`SAD_AREA_LSB];
        slot = addr[`SAD_SLOT_MSB:`SAD_SLOT_LSB];
        r.valid = 1'b1;
        r.offset = addr[`SAD_OFFSET_MSB:0];
        if (area == `SAD_AREA_INT) begin
            unique case (slot)
                `SAD_SLOT_BOOT: begin
                    if (remap) begin
                        r.sram = 1'b1;
                    end else if (boot_rom) begin
                        r.rom = 1'b1;
                    end else begin
                        r.abort = 1'b1;
                    end
                end
                `SAD_SLOT_ROM: r.rom = 1'b1;
                `SAD_SLOT_SRAM: r.sram = 1'b1;
                `SAD_SLOT_USB_HOST: r.usb_host = 1'b1;
                default: r.abort = 1'b1;
            endcase
        end else if (area <= `SAD_AREA_CS_LAST) begin
            // One chip select per area, in area order
            r.ext_cs = 8'h01 << (area - `SAD_AREA_CS_FIRST);
        end else if (area == `SAD_AREA_PERIPH) begin
            r.periph = 1'b1;
        end else begin
            r.abort = 1'b1;
        end
        return r;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************

    // Synchronisers, strap capture, remap flag, routing, interrupts
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = {boot_memory_select_in, external_interrupt_line_in,
                         fast_interrupt_line_in};
        st_nxt.pin_s2 = st_r.pin_s1;
        // Strap followed only in the first cycles after reset release
        if (st_r.strap_cnt != `SAD_STRAP_CYCLES) begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            st_nxt.boot_rom = st_r.pin_s2[`SAD_PIN_BOOT];
        end
        if (remap_cmd_in) begin
            st_nxt.remap = 1'b1;
        end
        // ROM alias at address 0 ends for good once remap is set
        if (st_nxt.remap) begin
            st_nxt.boot_rom = 1'b0;
        end
        if (req_valid_in) begin
            st_nxt.route = decode(req_addr_in, st_r.remap, st_r.boot_rom);
        end else begin
            st_nxt.route = '0;
        end
        // Identifier map shared by interrupt and clock gate vectors
        st_nxt.irq_vec = periph_irq_in;
        st_nxt.irq_vec[`SAD_ID_FAST] = st_r.pin_s2[`SAD_PIN_FAST];
        st_nxt.irq_vec[`SAD_ID_SYS] = |sys_irq_in;
        st_nxt.irq_vec[`SAD_ID_EXT_HI:`SAD_ID_EXT_LO] =
            st_r.pin_s2[`SAD_PIN_EXT_MSB:`SAD_PIN_EXT_LSB];
        st_nxt.clk_en = clk_en_req_in & `SAD_GATE_MASK;
    end

    // State register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign route_out = st_r.route;
    assign remap_active_out = st_r.remap;
    assign boot_rom_alias_out = st_r.boot_rom;
    assign irq_vec_out = st_r.irq_vec;
    assign clk_en_out = st_r.clk_en;

    // ************************************************************
    // Assertions
    // ************************************************************

    property p_cs_area;
        @(posedge mclk_in) disable iff (!rst_n_in)
        req_valid_in && req_addr_in[31:28] >= 4'h1
            && req_addr_in[31:28] <= 4'h8
        |=> route_out.ext_cs == 8'(8'h01 << ($past(req_addr_in[31:28]) - 4'h1))
            && !route_out.abort && route_out.valid;
    endproperty
    a_cs_area: assert property (p_cs_area)
        else $error("chip select does not match area");

    property p_abort_area;
        @(posedge mclk_in) disable iff (!rst_n_in)
        req_valid_in && req_addr_in[31:28] >= 4'h9
            && req_addr_in[31:28] <= 4'he
        |=> route_out.abort && route_out.ext_cs == 8'h00 && !route_out.periph;
    endproperty
    a_abort_area: assert property (p_abort_area)
        else $error("unused area not aborted");

    property p_periph;
        @(posedge mclk_in) disable iff (!rst_n_in)
        req_valid_in && req_addr_in[31:28] == 4'hf
        |=> route_out.periph && !route_out.abort;
    endproperty
    a_periph: assert property (p_periph)
        else $error("area 15 not routed to peripherals");

    property p_one_target;
        @(posedge mclk_in) disable iff (!rst_n_in)
        route_out.valid |-> $onehot({route_out.abort, route_out.periph,
            route_out.usb_host, route_out.rom, route_out.sram,
            route_out.ext_cs});
    endproperty
    a_one_target: assert property (p_one_target)
        else $error("access routed to zero or several targets");

    property p_fixed_mem;
        @(posedge mclk_in) disable iff (!rst_n_in)
        req_valid_in && req_addr_in[31:22] == 10'h000
            && req_addr_in[21:20] != 2'h0
        |=> (route_out.rom == ($past(req_addr_in[21:20]) == 2'h1))
            && (route_out.sram == ($past(req_addr_in[21:20]) == 2'h2))
            && (route_out.usb_host == ($past(req_addr_in[21:20]) == 2'h3));
    endproperty
    a_fixed_mem: assert property (p_fixed_mem)
        else $error("fixed internal slot misrouted");

    property p_boot_slot;
        @(posedge mclk_in) disable iff (!rst_n_in)
        req_valid_in && req_addr_in[31:20] == 12'h000
        |=> route_out.sram == $past(remap_active_out)
            && route_out.rom == $past(boot_rom_alias_out);
    endproperty
    a_boot_slot: assert property (p_boot_slot)
        else $error("address 0 alias wrong for remap state");

    property p_remap_sticky;
        @(posedge mclk_in) disable iff (!rst_n_in)
        remap_cmd_in or remap_active_out |=> remap_active_out;
    endproperty
    a_remap_sticky: assert property (p_remap_sticky)
        else $error("remap flag lost or not set");

    property p_sys_irq;
        @(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |=> irq_vec_out[1] == |$past(sys_irq_in);
    endproperty
    a_sys_irq: assert property (p_sys_irq)
        else $error("system interrupt not the OR of its sources");

    property p_fast_path;
        @(posedge mclk_in) disable iff (!rst_n_in)
        fast_interrupt_line_in [*3] |=> irq_vec_out[0];
    endproperty
    a_fast_path: assert property (p_fast_path)
        else $error("fast line not on identifier 0 after sync");

    property p_gate;
        @(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |=> clk_en_out[1:0] == 2'h0 && clk_en_out[31:25] == 7'h00
            && clk_en_out[24:2] == $past(clk_en_req_in[24:2]);
    endproperty
    a_gate: assert property (p_gate)
        else $error("clock gate map wrong");

    property p_periph_irq;
        @(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |=> irq_vec_out[24:2] == $past(periph_irq_in[24:2]);
    endproperty
    a_periph_irq: assert property (p_periph_irq)
        else $error("peripheral interrupt not on its identifier");

    c_remap: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        remap_cmd_in ##1 remap_active_out);
    c_boot_rom: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        route_out.rom && boot_rom_alias_out);
    c_abort: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        route_out.abort);
    c_cs7: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        route_out.ext_cs[7]);
endmodule

// ---- sad_decoder_tb.sv ----
// Self-checking testbench for the system address decoder
`timescale 1ns/10ps
module sad_decoder_tb;
    import sad_pkg::*;
    logic mclk_in, rst_n_in, req_valid_in, remap_cmd_in, boot_sel, fast;
    logic [31:0] req_addr_in, periph_irq, clk_req, irq_vec, clk_en, rnd;
    logic [6:0] ext;
    logic remap_act, alias_rom, m_remap, m_strap;
    sad_sys_irq_t sys_irq;
    sad_route_t route_out, e;
    sad_route_t q[$];
    int miscompares, checks_done;
    sad_bus_master m (.mclk_in(mclk_in), .req_valid_out(req_valid_in),
        .req_addr_out(req_addr_in));
    sad_decoder dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .req_valid_in(req_valid_in), .req_addr_in(req_addr_in),
        .remap_cmd_in(remap_cmd_in), .boot_memory_select_in(boot_sel),
        .fast_interrupt_line_in(fast), .external_interrupt_line_in(ext),
        .sys_irq_in(sys_irq), .periph_irq_in(periph_irq),
        .clk_en_req_in(clk_req), .route_out(route_out),
        .remap_active_out(remap_act), .boot_rom_alias_out(alias_rom),
        .irq_vec_out(irq_vec), .clk_en_out(clk_en));
    // ****************
    // Helpers
    // ****************
    task automatic chk(string nm, logic [63:0] x, logic [63:0] s);
        checks_done++;
        if (x !== s) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic sad_route_t exp_route(logic [31:0] a);
        sad_route_t r;
        r = '0;
        r.valid = 1'b1;
        r.offset = a[27:0];
        if (a[31:28] == 4'h0) begin
            case (a[27:20])
                8'h00: if (m_remap) r.sram = 1'b1;
                    else if (m_strap) r.rom = 1'b1;
                    else r.abort = 1'b1;
                8'h01: r.rom = 1'b1;
                8'h02: r.sram = 1'b1;
                8'h03: r.usb_host = 1'b1;
                default: r.abort = 1'b1;
            endcase
        end else if (a[31:28] <= 4'h8) begin
            r.ext_cs = 8'h01 << (a[31:28] - 4'h1);
        end else if (a[31:28] == 4'hf) begin
            r.periph = 1'b1;
        end else begin
            r.abort = 1'b1;
        end
        return r;
    endfunction
    task automatic acc(logic [31:0] a);
        q.push_back(exp_route(a));
        m.access(a);
    endtask
    task automatic sweep();
        acc(32'h0000_0010);
        acc(32'h0010_0004);
        acc(32'h0020_0008);
        acc(32'h0030_000c);
        acc(32'h0040_0000);
        for (int a = 1; a < 16; a++) begin
            acc({a[3:0], 28'h5a5_a5a5});
        end
        m.release_bus();
        repeat (3) @(negedge mclk_in);
    endtask
    task automatic do_reset(logic s);
        rst_n_in = 1'b0;
        boot_sel = s;
        m_strap = s;
        m_remap = 1'b0;
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
        chk("rst_route", 64'h0, route_out);
        rst_n_in = 1'b1;
        repeat (6) @(negedge mclk_in);
        chk("remap", 64'h0, remap_act);
        chk("alias", {63'h0, s}, alias_rom);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************
    // Clock, monitor, watchdog
    // ****************
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    // Compare each route result with the oldest note
    initial forever begin
        @(posedge mclk_in);
        #2;
        if (route_out.valid === 1'b1) begin
            if (q.size() == 0) begin
                chk("route_extra", 64'h0, 64'h1);
            end else begin
                e = q.pop_front();
                chk("route", e, route_out);
            end
        end
    end
    // Cut a hang short
    initial begin
        #(25 * 3000);
        miscompares++;
        complete_run();
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        rst_n_in = 1'b0;
        remap_cmd_in = 1'b0;
        {boot_sel, fast, ext, sys_irq, periph_irq, clk_req} = '0;
        rnd = 32'h43;
        miscompares = 0;
        checks_done = 0;
        do_reset(1'b1);
        sweep();
        @(negedge mclk_in);
        remap_cmd_in = 1'b1;
        @(negedge mclk_in);
        remap_cmd_in = 1'b0;
        m_remap = 1'b1;
        chk("remap", 64'h1, remap_act);
        chk("alias", 64'h0, alias_rom);
        sweep();
        // Interrupt merge and clock gate masking
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            @(negedge mclk_in);
            sys_irq = (i < 5) ? sad_sys_irq_t'(5'h01 << i) : rnd[4:0];
            {ext, fast} = rnd[12:5];
            periph_irq = rnd;
            clk_req = ~rnd;
            acc(rnd);
            m.release_bus();
            repeat (3) @(negedge mclk_in);
            chk("irq", {ext, rnd[24:2], |sys_irq, fast}, irq_vec);
            chk("gate", ~rnd & 32'h01ff_fffc, clk_en);
        end
        do_reset(1'b0);
        sweep();
        chk("queue", 64'h0, q.size());
        complete_run();
    end
endmodule

// ---- sad_pkg.sv ----
// Types shared by the system address decoder
package sad_pkg;
    // System peripheral interrupt lines merged into one source
    typedef struct packed {
        logic mc;
        logic dbgu;
        logic st;
        logic rtc;
        logic pmu;
    } sad_sys_irq_t;
    // Decoded target of one access
    typedef struct packed {
        logic valid;
        logic abort;
        logic periph;
        logic usb_host;
        logic rom;
        logic sram;
        logic [7:0] ext_cs;
        logic [27:0] offset;
    } sad_route_t;
    // Whole state of the decoder
    typedef struct packed {
        logic [8:0] pin_s1;
        logic [8:0] pin_s2;
        logic [1:0] strap_cnt;
        logic boot_rom;
        logic remap;
        sad_route_t route;
        logic [31:0] irq_vec;
        logic [31:0] clk_en;
    } sad_state_t;
endpackage
